// ### rsca_pkg.sv
// Shared types and constants for the rotate and subtract-with-borrow datapath
package rsca_pkg;
   localparam int DATA_W = 8;
   localparam int NIBBLE_W = 4;
   localparam int MSB_POS = 7;
   localparam int NIBBLE_POS = 4;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [7:0] MEM_WR_RESET = 8'h00;
   localparam logic [5:0] FLAGS_RESET = 6'h00;
   localparam int RESULT_LATENCY = 1;

   typedef enum logic [1:0] {
      OP_ROT_RIGHT_CARRY_ACC = 2'h0,
      OP_SUB_BORROW_MEM_SRC = 2'h1,
      OP_SUB_BORROW_IMM = 2'h2,
      OP_SUB_BORROW_TO_MEM = 2'h3
   } rsca_op_type;

   typedef struct packed {
      logic overflowFlag;
      logic zeroFlag;
      logic auxCarryFlag;
      logic carryFlag;
      logic extraStatusFlagS;
      logic chainedZeroFlag;
   } rsca_flags_type;

   typedef struct packed {
      logic valid;
      rsca_op_type op;
      logic [7:0] memData;
      logic [7:0] immData;
   } rsca_req_type;

   typedef struct packed {
      logic valid;
      logic [7:0] acc;
      rsca_flags_type flags;
   } rsca_load_type;
endpackage

// ### rsca_sub_unit.sv
// Combinational subtract-with-borrow core with flag generation
`timescale 1ns/100ps
module rsca_sub_unit (
   input wire logic [7:0] minuend,
   input wire logic [7:0] subtrahend,
   input wire rsca_pkg::rsca_flags_type flagsIn,
   output logic [7:0] diff,
   output rsca_pkg::rsca_flags_type flagsOut
);
   import rsca_pkg::*;

   logic [8:0] fullSum;
   logic [4:0] lowSum;
   logic overflow;

   // Subtraction as minuend plus inverted subtrahend plus carry
   always_comb begin
      fullSum = {1'b0, minuend} + {1'b0, ~subtrahend} + {8'h00, flagsIn.carryFlag};
      lowSum = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + {4'h0, flagsIn.carryFlag};
      diff = fullSum[7:0];
      overflow = (minuend[MSB_POS] != subtrahend[MSB_POS]) &&
                 (fullSum[MSB_POS] != minuend[MSB_POS]);
      flagsOut.overflowFlag = overflow; // [RULE8]
      flagsOut.zeroFlag = (fullSum[7:0] == 8'h00); // [RULE7]
      flagsOut.auxCarryFlag = lowSum[NIBBLE_POS]; // [RULE8]
      flagsOut.carryFlag = fullSum[DATA_W]; // [RULE6]
      flagsOut.extraStatusFlagS = fullSum[MSB_POS] ^ overflow; // [RULE7]
      flagsOut.chainedZeroFlag = (fullSum[7:0] == 8'h00) && flagsIn.chainedZeroFlag; // [RULE7]
   end
endmodule

// ### rsca_alu.sv
// Rotate-through-carry and subtract-with-borrow datapath with accumulator and flags
//
// Contract
// (RULE1) Rotate right through carry: acc gets {C, m[7:1]}, C gets m[0].
// (RULE2) Rotate leaves memory untouched; only accumulator and carry change.
// (RULE3) Subtract with borrow, memory source: acc gets acc minus m minus not C.
// (RULE4) Subtract with borrow, immediate: acc gets acc minus imm minus not C.
// (RULE5) Subtract to memory: memory gets acc minus m minus not C; acc kept.
// (RULE6) Subtract clears carry on borrow, sets it when result zero or positive.
// (RULE7) All subtracts update overflow, zero, aux, carry and both extra flags.
// (RULE8) Eight-bit operands; overflow is signed, aux carry means no nibble borrow.
`timescale 1ns/100ps
module rsca_alu (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire rsca_pkg::rsca_req_type opReq,
   input wire rsca_pkg::rsca_load_type loadReq,
   output logic [7:0] acc,
   output rsca_pkg::rsca_flags_type flags,
   output logic memWrEn,
   output logic [7:0] memWrData,
   output logic opDone
);
   import rsca_pkg::*;

   logic rstMeta;
   logic rstSync;
   logic [7:0] subOperand;
   logic [7:0] subDiff;
   rsca_flags_type subFlags;
   logic isRotate;
   logic isSubtract;

   // Decodes one operation code on a live request
   function automatic logic opIs(input rsca_req_type req, input rsca_op_type code);
      return req.valid && (req.op == code);
   endfunction

   // Reset release through two flip-flops
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rstMeta <= 1'b0;
         rstSync <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstSync <= rstMeta;
      end
   end

   always_comb begin
      isRotate = opIs(opReq, OP_ROT_RIGHT_CARRY_ACC);
      isSubtract = opReq.valid && (opReq.op != OP_ROT_RIGHT_CARRY_ACC);
      subOperand = (opReq.op == OP_SUB_BORROW_IMM) ? opReq.immData : opReq.memData; // [RULE4]
   end

   rsca_sub_unit subUnit (
      .minuend(acc),
      .subtrahend(subOperand),
      .flagsIn(flags),
      .diff(subDiff),
      .flagsOut(subFlags)
   );

   // Accumulator update
   always_ff @(posedge ref_clk or negedge rstSync) begin
      if (!rstSync) begin
         acc <= ACC_RESET;
      end else if (isRotate) begin
         acc <= {flags.carryFlag, opReq.memData[7:1]}; // [RULE1]
      end else if (isSubtract && (opReq.op != OP_SUB_BORROW_TO_MEM)) begin
         acc <= subDiff; // [RULE3] [RULE4]
      end else if (!opReq.valid && loadReq.valid) begin
         acc <= loadReq.acc;
      end
   end

   // Status flag update
   always_ff @(posedge ref_clk or negedge rstSync) begin
      if (!rstSync) begin
         flags <= FLAGS_RESET;
      end else if (isRotate) begin
         flags.carryFlag <= opReq.memData[0]; // [RULE1]
      end else if (isSubtract) begin
         flags <= subFlags; // [RULE6] [RULE7]
      end else if (loadReq.valid) begin
         flags <= loadReq.flags;
      end
   end

   // Data memory write-back, only for the subtract-to-memory form
   always_ff @(posedge ref_clk or negedge rstSync) begin
      if (!rstSync) begin
         memWrEn <= 1'b0;
         memWrData <= MEM_WR_RESET;
      end else begin
         memWrEn <= opIs(opReq, OP_SUB_BORROW_TO_MEM); // [RULE2] [RULE5]
         memWrData <= opIs(opReq, OP_SUB_BORROW_TO_MEM) ? subDiff : memWrData; // [RULE5]
      end
   end

   // Completion pulse
   always_ff @(posedge ref_clk or negedge rstSync) begin
      if (!rstSync) begin
         opDone <= 1'b0;
      end else begin
         opDone <= opReq.valid;
      end
   end

   default clocking defClk @(posedge ref_clk);
   endclocking
   default disable iff (!rstSync);

   // Reference values for the operand-dependent assertions
   logic [8:0] needMem;
   logic [8:0] needImm;
   logic [4:0] needNibble;
   logic [4:0] needNibbleImm;
   logic borrowIn;
   always_comb begin
      borrowIn = ~flags.carryFlag;
      needMem = {1'b0, opReq.memData} + {8'h00, borrowIn};
      needImm = {1'b0, opReq.immData} + {8'h00, borrowIn};
      needNibble = {1'b0, opReq.memData[3:0]} + {4'h0, borrowIn};
      needNibbleImm = {1'b0, opReq.immData[3:0]} + {4'h0, borrowIn};
   end

   rotate_acc_a: assert property (isRotate |=> // [RULE1]
      acc == {$past(flags.carryFlag), $past(opReq.memData[7:1])} &&
      flags.carryFlag == $past(opReq.memData[0]))
      else $error("Rotate result or carry wrong");

   rotate_keep_a: assert property (isRotate |=> !memWrEn && // [RULE2]
      flags.overflowFlag == $past(flags.overflowFlag) &&
      flags.zeroFlag == $past(flags.zeroFlag) &&
      flags.auxCarryFlag == $past(flags.auxCarryFlag) &&
      flags.extraStatusFlagS == $past(flags.extraStatusFlagS) &&
      flags.chainedZeroFlag == $past(flags.chainedZeroFlag))
      else $error("Rotate touched memory or other flags");

   sub_mem_a: assert property ( // [RULE3]
      opReq.valid && opReq.op == OP_SUB_BORROW_MEM_SRC |=>
      acc == 8'($past(acc) - $past(opReq.memData) - {7'h00, ~$past(flags.carryFlag)}) &&
      !memWrEn)
      else $error("Memory-source subtract result wrong");

   sub_imm_a: assert property ( // [RULE4]
      opReq.valid && opReq.op == OP_SUB_BORROW_IMM |=>
      acc == 8'($past(acc) - $past(opReq.immData) - {7'h00, ~$past(flags.carryFlag)}))
      else $error("Immediate subtract result wrong");

   sub_to_mem_a: assert property ( // [RULE5]
      opReq.valid && opReq.op == OP_SUB_BORROW_TO_MEM |=>
      memWrEn && acc == $past(acc) &&
      memWrData == 8'($past(acc) - $past(opReq.memData) - {7'h00, ~$past(flags.carryFlag)}))
      else $error("Subtract to memory wrong");

   sub_carry_a: assert property (isSubtract |=> // [RULE6]
      flags.carryFlag == ({1'b0, $past(acc)} >=
         (($past(opReq.op) == OP_SUB_BORROW_IMM) ? $past(needImm) : $past(needMem))))
      else $error("Subtract carry wrong");

   sub_zero_a: assert property ( // [RULE7]
      opReq.valid && opReq.op == OP_SUB_BORROW_TO_MEM |=>
      flags.zeroFlag == (memWrData == 8'h00) &&
      flags.chainedZeroFlag == ((memWrData == 8'h00) && $past(flags.chainedZeroFlag)))
      else $error("Subtract zero flags wrong");

   sub_signed_a: assert property ( // [RULE8]
      opReq.valid && opReq.op == OP_SUB_BORROW_MEM_SRC |=>
      flags.overflowFlag == (($past(acc[7]) != $past(opReq.memData[7])) &&
                             (acc[7] != $past(acc[7]))) &&
      flags.auxCarryFlag == ({1'b0, $past(acc[3:0])} >= $past(needNibble)) &&
      flags.extraStatusFlagS == (acc[7] ^ flags.overflowFlag))
      else $error("Subtract overflow or aux flag wrong");

   op_done_a: assert property (opReq.valid |=> opDone ##1 (opDone == $past(opReq.valid)))
      else $error("Done pulse mistimed");

   sub_src_zero_a: assert property ( // [RULE7]
      opIs(opReq, OP_SUB_BORROW_MEM_SRC) |=>
      flags.zeroFlag == (acc == 8'h00) &&
      flags.chainedZeroFlag == ((acc == 8'h00) && $past(flags.chainedZeroFlag)))
      else $error("Memory-source subtract zero flags wrong");

   sub_imm_flags_a: assert property ( // [RULE7]
      opIs(opReq, OP_SUB_BORROW_IMM) |=>
      flags.zeroFlag == (acc == 8'h00) &&
      flags.chainedZeroFlag == ((acc == 8'h00) && $past(flags.chainedZeroFlag)) &&
      flags.extraStatusFlagS == (acc[7] ^ flags.overflowFlag))
      else $error("Immediate subtract zero or sign flags wrong");

   imm_signed_a: assert property ( // [RULE8]
      opIs(opReq, OP_SUB_BORROW_IMM) |=>
      flags.overflowFlag == (($past(acc[7]) != $past(opReq.immData[7])) &&
                             (acc[7] != $past(acc[7]))) &&
      flags.auxCarryFlag == ({1'b0, $past(acc[3:0])} >= $past(needNibbleImm)))
      else $error("Immediate subtract overflow or aux flag wrong");

   mem_signed_a: assert property ( // [RULE8]
      opIs(opReq, OP_SUB_BORROW_TO_MEM) |=>
      flags.overflowFlag == (($past(acc[7]) != $past(opReq.memData[7])) &&
                             (memWrData[7] != $past(acc[7]))) &&
      flags.auxCarryFlag == ({1'b0, $past(acc[3:0])} >= $past(needNibble)) &&
      flags.extraStatusFlagS == (memWrData[7] ^ flags.overflowFlag))
      else $error("Memory-destination overflow or aux flag wrong");

   rotate_mem_a: assert property (isRotate |=> $stable(memWrData)) // [RULE2]
      else $error("Rotate changed the write data");

   idle_quiet_a: assert property (!opReq.valid |=> !opDone && !memWrEn && // [RULE5]
      $stable(memWrData))
      else $error("Pulse or write without an operation");

   load_take_a: assert property (!opReq.valid && loadReq.valid |=>
      acc == $past(loadReq.acc) && flags == $past(loadReq.flags))
      else $error("Load of accumulator and flags lost");

   // Main scenarios
   rotate_c: cover property (isRotate ##1 isRotate);
   borrow_c: cover property (isSubtract ##1 !flags.carryFlag);
   mem_wr_c: cover property (opReq.valid && opReq.op == OP_SUB_BORROW_TO_MEM ##1 memWrEn);
   chain_c: cover property (isSubtract ##1 isSubtract ##1 flags.chainedZeroFlag);
   load_c: cover property (!opReq.valid && loadReq.valid ##1 isSubtract);
endmodule

// ### rotate_subtract_carry_alu_tb_top.sv
// Self-checking testbench for the rotate and subtract-with-borrow datapath
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin totalChecks++; if ((ex) !== (gt)) begin errorCnt++; \
   $display("[ERR] %s expected %h seen %h", nm, ex, gt); end end
module rotate_subtract_carry_alu_tb_top;
   import rsca_pkg::*;
   typedef struct packed {
      logic [7:0] acc;
      rsca_flags_type flags;
      logic memWrEn;
      logic [7:0] memWrData;
   } rsca_exp_type;
   logic ref_clk, rst_b, memWrEn, opDone;
   rsca_req_type opReq;
   rsca_load_type loadReq;
   logic [7:0] acc, memWrData;
   rsca_flags_type flags;
   rsca_exp_type expQ[$];
   rsca_exp_type model, e;
   int errorCnt = 0, totalChecks = 0;
   integer seed = 32'h6b89997d;
   logic [7:0] bv [8] = '{8'h00, 8'hFF, 8'h80, 8'h7F, 8'h01, 8'h0F, 8'h10, 8'hF0};
   rsca_alu dut (.ref_clk(ref_clk), .rst_b(rst_b), .opReq(opReq), .loadReq(loadReq),
      .acc(acc), .flags(flags), .memWrEn(memWrEn), .memWrData(memWrData), .opDone(opDone));
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   // One request per cycle; reference state is advanced as the design should
   task automatic drive(input logic v, input rsca_op_type op, input logic [7:0] m,
         input logic [7:0] im, input logic lv, input logic [7:0] la, input rsca_flags_type lf);
      logic [8:0] d;
      logic [4:0] n;
      logic [7:0] a;
      logic nb;
      @(posedge ref_clk);
      #1;
      opReq = '{v, op, m, im};
      loadReq = '{lv, la, lf};
      if (v) begin
         a = model.acc;
         nb = ~model.flags.carryFlag;
         model.memWrEn = 1'b0;
         if (op == OP_ROT_RIGHT_CARRY_ACC) begin
            model.acc = {model.flags.carryFlag, m[7:1]};
            model.flags.carryFlag = m[0];
         end else begin
            if (op == OP_SUB_BORROW_IMM) m = im;
            d = {1'b0, a} - {1'b0, m} - nb;
            n = {1'b0, a[3:0]} - {1'b0, m[3:0]} - nb;
            model.flags.overflowFlag = (a[7] != m[7]) && (d[7] != a[7]);
            model.flags.zeroFlag = (d[7:0] == 8'h00);
            model.flags.auxCarryFlag = ~n[4];
            model.flags.carryFlag = ~d[8];
            model.flags.extraStatusFlagS = d[7] ^ model.flags.overflowFlag;
            model.flags.chainedZeroFlag = model.flags.zeroFlag & model.flags.chainedZeroFlag;
            if (op == OP_SUB_BORROW_TO_MEM) begin
               model.memWrEn = 1'b1;
               model.memWrData = d[7:0];
            end else begin
               model.acc = d[7:0];
            end
         end
         expQ.push_back(model);
      end else if (lv) begin
         model.acc = la;
         model.flags = lf;
      end
   endtask
   // Result watcher pops the oldest note on every completion pulse
   always @(negedge ref_clk) begin
      if (opDone === 1'b1) begin
         if (expQ.size() == 0) begin
            `CHK("opDone", 1'b0, opDone)
         end else begin
            e = expQ.pop_front();
            `CHK("acc", e.acc, acc)
            `CHK("flags", e.flags, flags)
            `CHK("memWrEn", e.memWrEn, memWrEn)
            `CHK("memWrData", e.memWrData, memWrData)
         end
      end
   end
   task automatic stopTest;
      $display("Checks %0d mismatches %0d", totalChecks, errorCnt);
      if (errorCnt == 0 && totalChecks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      #50000;
      errorCnt++;
      $display("Watchdog expired");
      stopTest;
   end
   initial begin
      logic [31:0] r, r2;
      opReq = '0;
      loadReq = '0;
      rst_b = 1'b0;
      model = '{ACC_RESET, FLAGS_RESET, 1'b0, MEM_WR_RESET};
      repeat (20) @(posedge ref_clk);
      `CHK("opDoneReset", 1'b0, opDone)
      #1 rst_b = 1'b1;
      repeat (3) @(posedge ref_clk);
      `CHK("accReset", ACC_RESET, acc)
      `CHK("flagsReset", FLAGS_RESET, flags)
      $display("Test reset done");
      for (int i = 0; i < 400; i++) begin
         r = $random(seed);
         r2 = $random(seed);
         drive(r[0] | r[1], rsca_op_type'(r[23:22]), r[31:24], r2[7:0], r[2], r[15:8],
            r[21:16]);
      end
      $display("Test random mix done");
      for (int k = 0; k < 4; k++) begin
         for (int j = 0; j < 8; j++) begin
            r = $random(seed);
            drive(1'b0, OP_ROT_RIGHT_CARRY_ACC, 8'h00, 8'h00, 1'b1, bv[j], r[5:0]);
            drive(1'b1, rsca_op_type'(k), bv[7 - j], bv[j ^ 3], 1'b0, 8'h00, 6'h00);
            drive(1'b1, rsca_op_type'(k), bv[j ^ 5], bv[7 - j], 1'b1, r[15:8], r[21:16]);
         end
      end
      $display("Test boundary values done");
      drive(1'b0, OP_ROT_RIGHT_CARRY_ACC, 8'h00, 8'h00, 1'b0, 8'h00, 6'h00);
      repeat (3) @(posedge ref_clk);
      `CHK("pendingResults", 0, expQ.size())
      stopTest;
   end
endmodule
